// *** design/cfg_port_pkg.sv ***
// Constants shared by both ends of the configuration port: I/O port
// addresses, key values, register indices, reset values and timing.
// Assumes a single 10 MHz system clock on both ends.
package cfg_port_pkg;
   // ************************************************************
   // I/O port addresses
   // ************************************************************
   localparam logic [7:0] IDX_PORT_LO = 8'h2e;  // Index port, low base
   localparam logic [7:0] DAT_PORT_LO = 8'h2f;  // Data port, low base
   localparam logic [7:0] IDX_PORT_HI = 8'h4e;  // Index port, high base
   localparam logic [7:0] DAT_PORT_HI = 8'h4f;  // Data port, high base
   // ************************************************************
   // Key values
   // ************************************************************
   localparam logic [7:0] KEY_ENTER = 8'h87;  // Written twice to unlock
   localparam logic [7:0] KEY_EXIT = 8'haa;  // Locks again
   // ************************************************************
   // Configuration register indices
   // ************************************************************
   localparam logic [7:0] IDX_LDN = 8'h07;  // Logical device select
   localparam logic [7:0] IDX_PIN_DIR = 8'hf0;  // Pin direction
   localparam logic [7:0] IDX_PIN_DATA = 8'hf1;  // Pin data
   localparam logic [7:0] IDX_PIN_POL = 8'hf2;  // Pin polarity
   localparam logic [7:0] IDX_WDT_ACT = 8'h30;  // Watchdog activate
   localparam logic [7:0] IDX_WDT_UNIT = 8'hf5;  // Watchdog count unit
   localparam logic [7:0] IDX_WDT_COUNT = 8'hf6;  // Watchdog count, reload
   localparam logic [7:0] LDN_GPIO = 8'h07;  // Pin bank
   localparam logic [7:0] LDN_WDT = 8'h08;  // Watchdog bank
   localparam logic [7:0] WDT_ACT_ON = 8'h01;  // Activate code
   localparam logic [7:0] WDT_UNIT_SEC = 8'h00;  // Seconds; else minutes
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_PIN_DIR = 8'hff;  // All inputs
   localparam logic [7:0] RST_PIN_DATA = 8'h00;
   localparam logic [7:0] RST_PIN_POL = 8'h00;
   localparam logic [7:0] RST_LDN = 8'h00;
   localparam logic [7:0] RST_WDT_ACT = 8'h00;
   localparam logic [7:0] RST_WDT_UNIT = 8'h00;
   localparam logic [7:0] RST_WDT_COUNT = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'hff;  // Answer while locked
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;  // 10 MHz
   localparam int SEC_NS = 1000000000;  // One second
   localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam int SEC_PER_MIN = 60;  // Minute unit
endpackage

// *** design/cfg_bus_if.sv ***
// Interface carrying the host's I/O read and write cycles to the
// configuration port. Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cfg_bus_if;
   logic [7:0] addr;  // I/O port address
   logic [7:0] wdata;  // Write data
   logic wr;  // Write strobe, one cycle
   logic rd;  // Read strobe, one cycle
   logic [7:0] rdata;  // Read answer
   logic rvalid;  // Answer valid, one cycle
   modport device (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
   modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface
`default_nettype wire

// *** design/wdt_timer.sv ***
// Watchdog down-counter with its own one-second divider.
// Assumes activation, unit and reload come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_timer #(
   parameter int SEC_CYCLES = cfg_port_pkg::SEC_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic active,  // Watchdog running
   input wire logic unit_min,  // Count in minutes
   input wire logic reload,  // Service pulse
   input wire logic [7:0] count,  // Timeout in units
   output logic expired  // One-cycle expiry pulse
);
   // ************************************************************
   // Second and minute ticks
   // ************************************************************
   logic [31:0] sec_cnt_r;  // Cycle divider
   logic [5:0] min_cnt_r;  // Second divider
   logic sec_tick;
   logic unit_tick;
   logic [7:0] remain_r;  // Units left
   logic run_r;  // Armed and counting

   assign sec_tick = (sec_cnt_r == 32'(SEC_CYCLES - 1));
   assign unit_tick = sec_tick && (!unit_min || (min_cnt_r == 6'(cfg_port_pkg::SEC_PER_MIN - 1)));

   // Divider restarts on every service so a period is always full
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_cnt_r <= 32'h0;
         min_cnt_r <= 6'h0;
      end else if (reload || !active || sec_tick) begin
         sec_cnt_r <= 32'h0;
         if (reload || !active) begin
            min_cnt_r <= 6'h0;
         end else if (unit_tick) begin
            min_cnt_r <= 6'h0;
         end else begin
            min_cnt_r <= min_cnt_r + 6'h1;
         end
      end else begin
         sec_cnt_r <= sec_cnt_r + 32'h1;
      end
   end

   // ************************************************************
   // Down-counter
   // ************************************************************
   // A count of zero leaves the watchdog disarmed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         remain_r <= 8'h0;
         run_r <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (!active) begin
            run_r <= 1'b0;
         end else if (reload || !run_r) begin
            remain_r <= count;
            run_r <= (count != 8'h0) && (reload || remain_r != 8'h0 || !run_r) && !(!run_r && !reload && remain_r == 8'h0 && expired);
         end else if (unit_tick) begin
            if (remain_r == 8'h1) begin
               expired <= 1'b1;
               run_r <= 1'b0;
               remain_r <= 8'h0;
            end else begin
               remain_r <= remain_r - 8'h1;
            end
         end
      end
   end
endmodule  // wdt_timer
`default_nettype wire

// *** design/cfg_port_device.sv ***
// Device end of the configuration port: key lock, index/data access,
// eight general-purpose pins and the watchdog.
// Assumes the host issues one-cycle strobes on the cfg_bus_if device side.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Direction bit 1 input, reset all inputs
// - Output pin data bit read/write, reset zero
// - Input pin data bit reads pin only
// - Polarity bit inverts pin value both ways
// - Write-only index port at 2Eh or 4Eh
// - Data port at 2Fh/4Fh reaches indexed register
// - Two 87H index writes unlock configuration
// - AAH to index port locks again
// - Index 07H selects bank; 07 gives pins
// - Bank 08H selects watchdog registers
// - Watchdog index 30H: 01 on, 00 off
// - Watchdog index F5H 00 counts seconds
// - Expiry resets processor or raises interrupt
module cfg_port_device #(
   parameter int SEC_CYCLES = cfg_port_pkg::SEC_CYCLES,  // Cycles per second
   parameter int PINS = 8  // Pin count
) (
   input wire logic clk,
   input wire logic reset_n,
   cfg_bus_if.device bus,
   input wire logic base_high,  // Strap: high base 4Eh/4Fh
   input wire logic wdt_use_irq,  // Expiry raises interrupt, not reset
   input wire logic [PINS-1:0] pin_in,  // Pin levels
   output logic [PINS-1:0] pin_out,  // Pin drive values
   output logic [PINS-1:0] pin_oe,  // Pin drive enables
   output logic wdt_cpu_reset,  // One-cycle processor reset pulse
   output logic wdt_irq  // Interrupt level
);
   // ************************************************************
   // Declarations
   // ************************************************************
   typedef enum logic [2:0] {
      LOCKED = 3'b001,
      KEY_ONE = 3'b010,
      OPEN = 3'b100
   } lock_state_t;
   lock_state_t lock_r;  // Key state
   logic [PINS-1:0] pin_s1_r;  // Pin sync, first stage
   logic [PINS-1:0] pin_s2_r;  // Pin sync, second stage
   logic [1:0] base_sync_r;  // Strap sync
   logic [1:0] base_age_r;  // Edges since release; strap caught at the third
   logic base_high_r;  // Caught base
   logic [7:0] idx_port;  // Active index port
   logic [7:0] dat_port;  // Active data port
   logic [7:0] index_r;  // Current index
   logic [7:0] ldn_r;  // Logical device
   logic [PINS-1:0] dir_r;  // Direction, 1 input
   logic [PINS-1:0] data_r;  // Data latch
   logic [PINS-1:0] pol_r;  // Polarity
   logic [7:0] wdt_act_r;  // Activation
   logic [7:0] wdt_unit_r;  // Unit
   logic [7:0] wdt_count_r;  // Timeout count
   logic idx_wr;  // Index port write
   logic dat_wr;  // Data port write, unlocked
   logic dat_rd;  // Data port read
   logic gpio_bank;  // Pin bank selected
   logic wdt_bank;  // Watchdog bank selected
   logic [PINS-1:0] pin_view;  // Pin value after polarity
   logic [PINS-1:0] data_view;  // Data register as read
   logic [7:0] read_nxt;  // Read answer
   logic wdt_reload;  // Service pulse
   logic wdt_expired;  // Expiry pulse

   // ************************************************************
   // Pin and strap synchronisers
   // ************************************************************
   // Two flops before any use
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         base_sync_r <= 2'h0;
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         base_sync_r <= {base_sync_r[0], base_high};
      end
   end

   // Strap caught once, after the synchroniser holds a real sample
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         base_age_r <= 2'h0;
         base_high_r <= 1'b0;
      end else if (base_age_r != 2'h3) begin
         base_age_r <= base_age_r + 2'h1;
         if (base_age_r == 2'h2) begin
            base_high_r <= base_sync_r[1];
         end
      end
   end

   // ************************************************************
   // Port decode
   // ************************************************************
   assign idx_port = base_high_r ? cfg_port_pkg::IDX_PORT_HI : cfg_port_pkg::IDX_PORT_LO;
   assign dat_port = base_high_r ? cfg_port_pkg::DAT_PORT_HI : cfg_port_pkg::DAT_PORT_LO;
   assign idx_wr = bus.wr && (bus.addr == idx_port);
   assign dat_wr = bus.wr && (bus.addr == dat_port) && (lock_r == OPEN);
   assign dat_rd = bus.rd && (bus.addr == dat_port) && (lock_r == OPEN);
   assign gpio_bank = (ldn_r == cfg_port_pkg::LDN_GPIO);
   assign wdt_bank = (ldn_r == cfg_port_pkg::LDN_WDT);

   // ************************************************************
   // Key lock
   // ************************************************************
   // Second key must follow the first directly on the index port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_r <= LOCKED;
      end else if (idx_wr) begin
         case (lock_r)
            LOCKED: begin
               lock_r <= (bus.wdata == cfg_port_pkg::KEY_ENTER) ? KEY_ONE : LOCKED;
            end
            KEY_ONE: begin
               lock_r <= (bus.wdata == cfg_port_pkg::KEY_ENTER) ? OPEN : LOCKED;
            end
            OPEN: begin
               lock_r <= (bus.wdata == cfg_port_pkg::KEY_EXIT) ? LOCKED : OPEN;
            end
            default: begin
               lock_r <= LOCKED;
            end
         endcase
      end
   end

   // Index taken only while open; the exit key is not stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_r <= 8'h0;
      end else if (idx_wr && lock_r == OPEN && bus.wdata != cfg_port_pkg::KEY_EXIT) begin
         index_r <= bus.wdata;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Logical device select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ldn_r <= cfg_port_pkg::RST_LDN;
      end else if (dat_wr && index_r == cfg_port_pkg::IDX_LDN) begin
         ldn_r <= bus.wdata;
      end
   end

   // Pin bank registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dir_r <= PINS'(cfg_port_pkg::RST_PIN_DIR);
         data_r <= PINS'(cfg_port_pkg::RST_PIN_DATA);
         pol_r <= PINS'(cfg_port_pkg::RST_PIN_POL);
      end else if (dat_wr && gpio_bank) begin
         case (index_r)
            cfg_port_pkg::IDX_PIN_DIR: begin
               dir_r <= bus.wdata[PINS-1:0];
            end
            cfg_port_pkg::IDX_PIN_DATA: begin
               // Input bits keep their latch
               data_r <= (data_r & dir_r) | (bus.wdata[PINS-1:0] & ~dir_r);
            end
            cfg_port_pkg::IDX_PIN_POL: begin
               pol_r <= bus.wdata[PINS-1:0];
            end
            default: begin
               data_r <= data_r;
            end
         endcase
      end
   end

   // Watchdog bank registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdt_act_r <= cfg_port_pkg::RST_WDT_ACT;
         wdt_unit_r <= cfg_port_pkg::RST_WDT_UNIT;
         wdt_count_r <= cfg_port_pkg::RST_WDT_COUNT;
      end else if (dat_wr && wdt_bank) begin
         case (index_r)
            cfg_port_pkg::IDX_WDT_ACT: begin
               wdt_act_r <= bus.wdata;
            end
            cfg_port_pkg::IDX_WDT_UNIT: begin
               wdt_unit_r <= bus.wdata;
            end
            cfg_port_pkg::IDX_WDT_COUNT: begin
               wdt_count_r <= bus.wdata;
            end
            default: begin
               wdt_count_r <= wdt_count_r;
            end
         endcase
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   assign pin_view = pin_s2_r ^ pol_r;
   assign data_view = (pin_view & dir_r) | (data_r & ~dir_r);

   // Unmapped indices read as zero
   always_comb begin
      read_nxt = 8'h0;
      if (index_r == cfg_port_pkg::IDX_LDN) begin
         read_nxt = ldn_r;
      end else if (gpio_bank) begin
         case (index_r)
            cfg_port_pkg::IDX_PIN_DIR: read_nxt = 8'(dir_r);
            cfg_port_pkg::IDX_PIN_DATA: read_nxt = 8'(data_view);
            cfg_port_pkg::IDX_PIN_POL: read_nxt = 8'(pol_r);
            default: read_nxt = 8'h0;
         endcase
      end else if (wdt_bank) begin
         case (index_r)
            cfg_port_pkg::IDX_WDT_ACT: read_nxt = wdt_act_r;
            cfg_port_pkg::IDX_WDT_UNIT: read_nxt = wdt_unit_r;
            cfg_port_pkg::IDX_WDT_COUNT: read_nxt = wdt_count_r;
            default: read_nxt = 8'h0;
         endcase
      end
   end

   // Every read answers one cycle later; locked or index port reads idle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.rdata <= 8'h0;
         bus.rvalid <= 1'b0;
      end else begin
         bus.rvalid <= bus.rd;
         bus.rdata <= dat_rd ? read_nxt : cfg_port_pkg::READ_IDLE;
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= data_r ^ pol_r;
         pin_oe <= ~dir_r;
      end
   end

   // ************************************************************
   // Watchdog
   // ************************************************************
   // Writing the count services the watchdog
   assign wdt_reload = dat_wr && wdt_bank && (index_r == cfg_port_pkg::IDX_WDT_COUNT);

   wdt_timer #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_wdt (
      .clk(clk),
      .reset_n(reset_n),
      .active(wdt_act_r == cfg_port_pkg::WDT_ACT_ON),
      .unit_min(wdt_unit_r != cfg_port_pkg::WDT_UNIT_SEC),
      .reload(wdt_reload),
      .count(wdt_count_r),
      .expired(wdt_expired)
   );

   // Expiry action; a new expiry wins over a clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdt_cpu_reset <= 1'b0;
         wdt_irq <= 1'b0;
      end else begin
         wdt_cpu_reset <= wdt_expired && !wdt_use_irq;
         if (wdt_expired && wdt_use_irq) begin
            wdt_irq <= 1'b1;
         end else if (wdt_reload || wdt_act_r != cfg_port_pkg::WDT_ACT_ON) begin
            wdt_irq <= 1'b0;
         end
      end
   end
endmodule  // cfg_port_device
`default_nettype wire

// *** design/cfg_port_host.sv ***
// Host end: turns one user command into the unlock, index, data and
// lock sequence on the configuration port.
// Assumes the device answers a read within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module cfg_port_host (
   input wire logic clk,
   input wire logic reset_n,
   cfg_bus_if.host bus,
   input wire logic base_high,  // Use 4Eh/4Fh
   input wire logic cmd_valid,  // Command request
   input wire logic cmd_write,  // 1 write, 0 read
   input wire logic [7:0] cmd_index,  // Register index
   input wire logic [7:0] cmd_wdata,  // Write value
   output logic cmd_ready,  // Idle, takes a command
   output logic rsp_valid,  // Command done, one cycle
   output logic [7:0] rsp_rdata  // Read value
);
   // ************************************************************
   // Declarations
   // ************************************************************
   typedef enum logic [5:0] {
      IDLE = 6'b000001,
      KEY1 = 6'b000010,
      KEY2 = 6'b000100,
      INDEX = 6'b001000,
      WAIT = 6'b010000,
      LOCK = 6'b100000
   } host_state_t;
   host_state_t state_r;  // Sequence state
   logic write_r;  // Latched direction
   logic [7:0] index_r;  // Latched index
   logic [7:0] wdata_r;  // Latched value
   logic [7:0] idx_port;
   logic [7:0] dat_port;

   assign idx_port = base_high ? cfg_port_pkg::IDX_PORT_HI : cfg_port_pkg::IDX_PORT_LO;
   assign dat_port = base_high ? cfg_port_pkg::DAT_PORT_HI : cfg_port_pkg::DAT_PORT_LO;

   // ************************************************************
   // Sequencer
   // ************************************************************
   // Each state names the bus cycle already on the wires
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= IDLE;
         write_r <= 1'b0;
         index_r <= 8'h0;
         wdata_r <= 8'h0;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h0;
         bus.addr <= 8'h0;
         bus.wdata <= 8'h0;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         rsp_valid <= 1'b0;
         case (state_r)
            IDLE: begin
               if (cmd_valid) begin
                  write_r <= cmd_write;
                  index_r <= cmd_index;
                  wdata_r <= cmd_wdata;
                  cmd_ready <= 1'b0;
                  bus.wr <= 1'b1;
                  bus.addr <= idx_port;
                  bus.wdata <= cfg_port_pkg::KEY_ENTER;
                  state_r <= KEY1;
               end
            end
            KEY1: begin
               bus.wr <= 1'b1;
               bus.wdata <= cfg_port_pkg::KEY_ENTER;
               state_r <= KEY2;
            end
            KEY2: begin
               bus.wr <= 1'b1;
               bus.wdata <= index_r;
               state_r <= INDEX;
            end
            INDEX: begin
               bus.addr <= dat_port;
               bus.wdata <= wdata_r;
               bus.wr <= write_r;
               bus.rd <= !write_r;
               state_r <= WAIT;
            end
            WAIT: begin
               if (write_r || bus.rvalid) begin
                  rsp_rdata <= write_r ? 8'h0 : bus.rdata;
                  bus.wr <= 1'b1;
                  bus.addr <= idx_port;
                  bus.wdata <= cfg_port_pkg::KEY_EXIT;
                  state_r <= LOCK;
               end
            end
            LOCK: begin
               rsp_valid <= 1'b1;
               cmd_ready <= 1'b1;
               state_r <= IDLE;
            end
            default: begin
               state_r <= IDLE;
               cmd_ready <= 1'b1;
            end
         endcase
      end
   end
endmodule  // cfg_port_host
`default_nettype wire

// *** verification/cfg_bus_properties.sv ***
// Checker on the bus joining host and device ends.
// Assumes one clock; takes the interface signals as inputs.
`timescale 1ns/1ps
`default_nettype none
module cfg_bus_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   logic [1:0] key_r; // Key progress, 2 unlocked
   logic idx; // Index port hit
   logic dat; // Data port hit
   logic acc; // Data port access
   assign idx = addr == 8'h2e || addr == 8'h4e;
   assign dat = addr == 8'h2f || addr == 8'h4f;
   assign acc = (wr || rd) && dat;
   // Follow the key from index writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) key_r <= 2'h0;
      else if (wr && idx) key_r <= key_r == 2'h2 ? (wdata == 8'haa ? 2'h0 : 2'h2) : (wdata == 8'h87 ? key_r + 2'h1 : 2'h0);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_read_answer: assert property (rd |=> rvalid) else $error("no answer");
   a_no_stray: assert property (rvalid |-> $past(rd)) else $error("stray answer");
   a_locked_idle: assert property (rd && dat && key_r != 2'h2 |=> rdata == 8'hff) else $error("locked read");
   a_index_idle: assert property (rd && idx |=> rdata == 8'hff) else $error("index read");
   a_key_pair: assert property (wr && idx && wdata == 8'h87 && key_r == 2'h0 |=> wr && wdata == 8'h87)
      else $error("key split");
   a_data_unlocked: assert property (acc |-> key_r == 2'h2) else $error("access while locked");
   a_relock_next: assert property (wr && dat |=> wr && idx && wdata == 8'haa) else $error("no relock");
   a_relock_read: assert property (rd && dat |-> ##2 (wr && idx && wdata == 8'haa)) else $error("no relock");
   a_index_first: assert property (acc |-> $past(wr) && $past(idx)) else $error("no index");
endmodule // cfg_bus_properties
`default_nettype wire

// *** verification/tb.sv ***
// Bench: host and device joined by the bus, and a second device
// driven directly. Assumes 10 MHz clock, second shortened to 10.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", what, e, g); end end
module tb;
   logic clk = 1'b0, reset_n = 1'b0, hi = 1'b0, use_irq = 1'b0, cv = 1'b0, cw = 1'b0, cr, rv, rst, irq;
   logic [7:0] ci = 8'h00, cd = 8'h00, rdat, pin_in = 8'h5a, pout, poe;
   int error_cnt = 0, comparisons = 0, n;
   cfg_bus_if bus_if ();
   cfg_bus_if bus2 ();
   always #50 clk = ~clk;
   cfg_port_host cfg_port_host_i (.clk(clk), .reset_n(reset_n), .bus(bus_if), .base_high(hi), .cmd_valid(cv),
      .cmd_write(cw), .cmd_index(ci), .cmd_wdata(cd), .cmd_ready(cr), .rsp_valid(rv), .rsp_rdata(rdat));
   cfg_port_device #(.SEC_CYCLES(10)) cfg_port_device_i (.clk(clk), .reset_n(reset_n), .bus(bus_if), .base_high(hi),
      .wdt_use_irq(use_irq), .pin_in(pin_in), .pin_out(pout), .pin_oe(poe), .wdt_cpu_reset(rst), .wdt_irq(irq));
   cfg_port_device #(.SEC_CYCLES(10)) cfg_port_device_i2 (.clk(clk), .reset_n(reset_n), .bus(bus2), .base_high(1'b0),
      .wdt_use_irq(1'b0), .pin_in(8'h00), .pin_out(), .pin_oe(), .wdt_cpu_reset(), .wdt_irq());
   cfg_bus_properties cfg_bus_properties_i (.clk(clk), .reset_n(reset_n), .addr(bus_if.addr), .wdata(bus_if.wdata),
      .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
   // One host command, then a bounded wait for completion
   task automatic cmd(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      #1 cv = 1'b1;
      cw = w;
      ci = i;
      cd = d;
      @(posedge clk);
      #1 cv = 1'b0;
      for (n = 0; n < 20 && rv !== 1'b1; n++) @(posedge clk) #1;
      `CHK("cmd_done", 2'b11, {rv, cr})
   endtask
   task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
      cmd(1'b0, i, 8'h00);
      `CHK(nm, e, rdat)
   endtask
   // Direct write on the second bus; data inverted once released
   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 bus2.wr = 1'b1;
      bus2.addr = a;
      bus2.wdata = d;
      @(posedge clk);
      #1 bus2.wr = 1'b0;
      bus2.wdata = ~d;
   endtask
   task automatic br(input string nm, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 bus2.rd = 1'b1;
      bus2.addr = a;
      @(posedge clk);
      #1 bus2.rd = 1'b0;
      `CHK(nm, e, bus2.rdata)
   endtask
   // Expiry must come, but not before most of two seconds
   task automatic wdt_wait(input string nm, ref logic s);
      for (n = 0; n < 40 && s !== 1'b1; n++) @(posedge clk) #1;
      `CHK(nm, 1'b1, s && n >= 15)
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      test_done;
   end
   initial begin
      bus2.wr = 1'b0;
      bus2.rd = 1'b0;
      bus2.addr = 8'h00;
      bus2.wdata = 8'h00;
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      `CHK("oe_rst", 8'h00, poe)
      cmd(1'b1, 8'h07, 8'h07);
      rchk("dir_rst", 8'hf0, 8'hff);
      rchk("data_in", 8'hf1, 8'h5a);
      cmd(1'b1, 8'hf0, 8'h0f);
      cmd(1'b1, 8'hf1, 8'ha5);
      `CHK("oe", 8'hf0, poe)
      `CHK("out", 8'ha0, pout)
      rchk("data_mix", 8'hf1, 8'haa);
      cmd(1'b1, 8'hf2, 8'hff);
      `CHK("out_inv", 8'h5f, pout)
      rchk("data_inv", 8'hf1, 8'ha5);
      $display("pins test over");
      cmd(1'b1, 8'h07, 8'h08);
      cmd(1'b1, 8'hf5, 8'h00);
      cmd(1'b1, 8'hf6, 8'h02);
      cmd(1'b1, 8'h30, 8'h01);
      wdt_wait("wdt_rst", rst);
      use_irq = 1'b1;
      wdt_wait("wdt_irq", irq);
      cmd(1'b1, 8'h30, 8'h00);
      `CHK("irq_off", 1'b0, irq)
      $display("watchdog test over");
      bw(8'h2e, 8'h07);
      bw(8'h2f, 8'h07);
      br("locked", 8'h2f, 8'hff);
      bw(8'h2e, 8'h87);
      bw(8'h2e, 8'h55);
      bw(8'h2e, 8'h87);
      br("bad_key", 8'h2f, 8'hff);
      bw(8'h2e, 8'h87);
      bw(8'h2e, 8'h07);
      br("ldn", 8'h2f, 8'h00);
      br("idx_rd", 8'h2e, 8'hff);
      bw(8'h2e, 8'haa);
      br("relocked", 8'h2f, 8'hff);
      $display("lock test over");
      reset_n = 1'b0;
      hi = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      cmd(1'b1, 8'h07, 8'h07);
      cmd(1'b1, 8'hf2, 8'h3c);
      rchk("hi_base", 8'hf2, 8'h3c);
      $display("base test over");
      test_done;
   end
endmodule // tb
`default_nettype wire
